/* File: pkg/orient_pkg.sv */
// constants, register map and lookup functions of the orientation threshold block
//
// Overview of operation
// - 3-bit z-lockout code in low bits of angle register, reset 4, max 7.
// - each lockout code spans a min to max angle; code 4 is 28.1 to 30.0 degrees.
// - 2-bit back/front code in top bits, reset 0b10 (70 degrees), 5 degree steps.
// - front to back needs z angle in a window narrowing 5 degrees per code.
// - 5-bit trip code in upper bits of threshold register sets the trip angle.
// - 3-bit hysteresis code widens the gap between the two trip angles.
// - upright y -1g, inverted y +1g, right x +1g, left x -1g.
// - lockout angles follow a fixed table, 13.6 to 43.4 degrees.
// - lockout flag set when tilt exceeds lockout angle, cleared otherwise.
// - orientation code 00 up, 01 down, 10 right, 11 left; separate back bit.
// - change flag set on first detection and on any change; cleared by status read.
package orient_pkg;

  // register indices as printed, byte address is four times the index
  localparam logic [7:0] IDX_BFZ        = 8'h13;
  localparam logic [7:0] IDX_TRIP       = 8'h14;
  localparam logic [7:0] ADDR_BFZ       = 8'(4 * IDX_BFZ);
  localparam logic [7:0] ADDR_TRIP      = 8'(4 * IDX_TRIP);
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CLR   = 8'h10;

  // reset values
  localparam logic [7:0] RST_BFZ        = 8'h84;
  localparam logic [7:0] RST_TRIP       = 8'h44;

  // field positions
  localparam int ZLOCK_LSB = 0;
  localparam int BKFR_LSB  = 6;
  localparam int HYS_LSB   = 0;
  localparam int TRIP_LSB  = 3;
  localparam int ST_NEW    = 7;
  localparam int ST_LOCK   = 6;
  localparam int ST_ORIENT = 1;
  localparam int ST_BACK   = 0;

  // orientation codes
  localparam logic [1:0] ORIENT_UPRIGHT  = 2'h0;
  localparam logic [1:0] ORIENT_INVERTED = 2'h1;
  localparam logic [1:0] ORIENT_RIGHT    = 2'h2;
  localparam logic [1:0] ORIENT_LEFT     = 2'h3;

  // axis counts: 1 g is 4096 counts, orientation frozen above 1.25 g
  localparam logic [13:0] LOCK_G_COUNTS = 14'h1400;
  localparam logic [6:0]  MAX_DEG       = 7'h55;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // tan squared of lockout angle (upper end of each span), q10
  function automatic logic [17:0] zlock_tan2(input logic [2:0] code);
    unique case (code)
      3'h0: zlock_tan2 = 18'h00044;
      3'h1: zlock_tan2 = 18'h0006F;
      3'h2: zlock_tan2 = 18'h000A7;
      3'h3: zlock_tan2 = 18'h000F1;
      3'h4: zlock_tan2 = 18'h00155;
      3'h5: zlock_tan2 = 18'h001D9;
      3'h6: zlock_tan2 = 18'h00291;
      3'h7: zlock_tan2 = 18'h00394;
    endcase
  endfunction

  // sin squared of the back/front margin 10+5*code degrees, q10
  function automatic logic [17:0] bkfr_sin2(input logic [1:0] code);
    unique case (code)
      2'h0: bkfr_sin2 = 18'h0001F;
      2'h1: bkfr_sin2 = 18'h00045;
      2'h2: bkfr_sin2 = 18'h00078;
      2'h3: bkfr_sin2 = 18'h000B7;
    endcase
  endfunction

  // tan squared at 5 degree steps, q10
  function automatic logic [17:0] tan2_step(input logic [4:0] i);
    unique case (i)
      5'h00: tan2_step = 18'h00000;
      5'h01: tan2_step = 18'h00008;
      5'h02: tan2_step = 18'h00020;
      5'h03: tan2_step = 18'h00049;
      5'h04: tan2_step = 18'h00088;
      5'h05: tan2_step = 18'h000DF;
      5'h06: tan2_step = 18'h00155;
      5'h07: tan2_step = 18'h001F6;
      5'h08: tan2_step = 18'h002D1;
      5'h09: tan2_step = 18'h00400;
      5'h0A: tan2_step = 18'h005AE;
      5'h0B: tan2_step = 18'h00829;
      5'h0C: tan2_step = 18'h00C00;
      5'h0D: tan2_step = 18'h01265;
      5'h0E: tan2_step = 18'h01E32;
      5'h0F: tan2_step = 18'h037B7;
      5'h10: tan2_step = 18'h080A4;
      default: tan2_step = 18'h20A8A;
    endcase
  endfunction

  // tan squared of a whole-degree angle, linear between table steps
  function automatic logic [17:0] tan2_deg(input logic [6:0] deg);
    logic [6:0]  d;
    logic [4:0]  i;
    logic [2:0]  f;
    logic [17:0] low_v;
    logic [17:0] hi_v;
    logic [20:0] step;
    d     = (deg > MAX_DEG) ? MAX_DEG : deg;
    i     = 5'(d / 7'h05);
    f     = 3'(d % 7'h05);
    low_v = tan2_step(i);
    hi_v  = tan2_step(5'(i + 5'h01));
    step  = 21'((21'(hi_v - low_v) * 21'(f)) / 21'h00005);
    tan2_deg = 18'(21'(low_v) + step);
  endfunction

  // base trip angle from the trip code
  function automatic logic [6:0] trip_base_deg(input logic [4:0] code);
    unique case (code)
      5'h07: trip_base_deg = 7'h0F;
      5'h09: trip_base_deg = 7'h14;
      5'h0C: trip_base_deg = 7'h1E;
      5'h0D: trip_base_deg = 7'h23;
      5'h0F: trip_base_deg = 7'h28;
      5'h10: trip_base_deg = 7'h2D;
      5'h13: trip_base_deg = 7'h37;
      5'h14: trip_base_deg = 7'h3C;
      5'h17: trip_base_deg = 7'h46;
      5'h19: trip_base_deg = 7'h4B;
      // product needs 9 bits before the shift, else codes above 17 wrap
      default: trip_base_deg = 7'((9'(code) * 9'h00F) >> 2);
    endcase
  endfunction

  // half gap between the two trip angles per hysteresis code
  function automatic logic [6:0] hys_deg(input logic [2:0] code);
    unique case (code)
      3'h0: hys_deg = 7'h00;
      3'h1: hys_deg = 7'h04;
      3'h2: hys_deg = 7'h07;
      3'h3: hys_deg = 7'h0B;
      3'h4: hys_deg = 7'h0E;
      3'h5: hys_deg = 7'h11;
      3'h6: hys_deg = 7'h15;
      3'h7: hys_deg = 7'h18;
    endcase
  endfunction

endpackage

/* File: rtl/angle_compare.sv */
// ratio comparator: num_sq > tan_sq * den_sq with tan_sq in q10
`timescale 1ns/1ns
module angle_compare (
  input  wire logic [26:0] num_sq,
  input  wire logic [27:0] den_sq,
  input  wire logic [17:0] tan_sq,
  output logic             above
);
  logic [45:0] lhs;
  logic [45:0] rhs;

  // squares avoid a square root; q10 scaling of num matches tan_sq
  always_comb begin
    lhs   = {9'h000, num_sq, 10'h000};
    rhs   = 46'(tan_sq) * 46'(den_sq);
    above = lhs > rhs;
  end
endmodule

/* File: rtl/orientation_threshold_config.sv */
// orientation detector with threshold registers behind an axi4-lite slave
`timescale 1ns/1ns
module orientation_threshold_config (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  output logic [1:0]              s_axi_bresp,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  input  wire logic [7:0]         s_axi_araddr,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  input  wire logic               sample_valid,
  input  wire logic signed [13:0] accel_x,
  input  wire logic signed [13:0] accel_y,
  input  wire logic signed [13:0] accel_z,
  output logic [1:0]              orient_code,
  output logic                    back_facing,
  output logic                    tilt_lockout_flag,
  output logic                    orient_change,
  output logic                    irq
);

  typedef struct packed {
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        enable;
    logic [7:0]  bfz;
    logic [7:0]  trip;
    logic        chg_flag;
    logic        lockout;
    logic [1:0]  orient;
    logic        back;
    logic        first_pending;
    logic [1:0]  irq_status;
    logic [1:0]  irq_enable;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  function automatic logic [26:0] square(input logic signed [13:0] v);
    logic signed [27:0] p;
    p = 28'(v) * 28'(v);
    square = p[26:0];
  endfunction

  function automatic logic [13:0] magnitude(input logic signed [13:0] v);
    magnitude = v[13] ? 14'(-v) : 14'(v);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // angle comparisons on the current sample

  logic [26:0] x_sq;
  logic [26:0] y_sq;
  logic [26:0] z_sq;
  logic [27:0] xy_sq;
  logic [27:0] xyz_sq;
  logic [6:0]  base_deg;
  logic [6:0]  gap_deg;
  logic [6:0]  to_portrait_deg;
  logic [6:0]  to_land_deg;
  logic [7:0]  portrait_sum;
  logic        tilt_over;
  logic        bf_over;
  logic        past_to_portrait;
  logic        past_to_land;

  // angle derivation shared by all four comparators
  always_comb begin
    x_sq            = square(accel_x);
    y_sq            = square(accel_y);
    z_sq            = square(accel_z);
    xy_sq           = 28'(x_sq) + 28'(y_sq);
    xyz_sq          = xy_sq + 28'(z_sq);
    base_deg        = orient_pkg::trip_base_deg(st_ff.trip[orient_pkg::TRIP_LSB +: 5]);
    gap_deg         = orient_pkg::hys_deg(st_ff.trip[orient_pkg::HYS_LSB +: 3]);
    // the sum can pass 85 degrees; saturate rather than wrap to a small angle
    portrait_sum    = 8'(base_deg) + 8'(gap_deg);
    to_portrait_deg = (portrait_sum > 8'(orient_pkg::MAX_DEG)) ? orient_pkg::MAX_DEG
                                                               : 7'(portrait_sum);
    to_land_deg     = (base_deg > gap_deg) ? 7'(base_deg - gap_deg) : 7'h00;
  end

  // lockout: z tilt beyond the lockout angle measured from the xy plane
  angle_compare u_tilt (
    .num_sq (z_sq),
    .den_sq (xy_sq),
    .tan_sq (orient_pkg::zlock_tan2(st_ff.bfz[orient_pkg::ZLOCK_LSB +: 3])),
    .above  (tilt_over)
  );

  // back/front: z component beyond the sine of the window margin
  angle_compare u_bkfr (
    .num_sq (z_sq),
    .den_sq (xyz_sq),
    .tan_sq (orient_pkg::bkfr_sin2(st_ff.bfz[orient_pkg::BKFR_LSB +: 2])),
    .above  (bf_over)
  );

  // landscape to portrait trip, the wider angle
  angle_compare u_to_portrait (
    .num_sq (y_sq),
    .den_sq (28'(x_sq)),
    .tan_sq (orient_pkg::tan2_deg(to_portrait_deg)),
    .above  (past_to_portrait)
  );

  // portrait to landscape trip, the narrower angle
  angle_compare u_to_land (
    .num_sq (y_sq),
    .den_sq (28'(x_sq)),
    .tan_sq (orient_pkg::tan2_deg(to_land_deg)),
    .above  (past_to_land)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        do_write;
  logic        status_read;
  logic        take;
  logic        high_g;
  logic        det_lock;
  logic        det_back;
  logic [1:0]  det_orient;
  logic        changed;
  logic [1:0]  events;

  always_comb begin
    nxt_st      = st_ff;
    aw_hs       = s_axi_awvalid && s_axi_awready;
    w_hs        = s_axi_wvalid && s_axi_wready;
    ar_hs       = s_axi_arvalid && s_axi_arready;
    do_write    = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
    status_read = ar_hs && (s_axi_araddr == orient_pkg::ADDR_STATUS);

    // detection, one evaluation per sample with registers as they stand
    high_g     = (magnitude(accel_x) > orient_pkg::LOCK_G_COUNTS) ||
                 (magnitude(accel_y) > orient_pkg::LOCK_G_COUNTS) ||
                 (magnitude(accel_z) > orient_pkg::LOCK_G_COUNTS);
    take       = sample_valid && st_ff.enable && !high_g;
    det_lock   = tilt_over;
    det_back   = st_ff.back;
    if (!st_ff.back && accel_z[13] && bf_over) begin
      det_back = 1'b1;
    end else if (st_ff.back && !accel_z[13] && bf_over) begin
      det_back = 1'b0;
    end
    det_orient = st_ff.orient;
    // lockout freezes the orientation code; hysteresis decides the class
    if (!det_lock) begin
      if (st_ff.orient[1] ? past_to_portrait : past_to_land) begin
        det_orient = accel_y[13] ? orient_pkg::ORIENT_UPRIGHT
                                 : orient_pkg::ORIENT_INVERTED;
      end else begin
        det_orient = accel_x[13] ? orient_pkg::ORIENT_LEFT
                                 : orient_pkg::ORIENT_RIGHT;
      end
    end
    changed = take && (st_ff.first_pending || det_lock != st_ff.lockout ||
                       det_back != st_ff.back || det_orient != st_ff.orient);
    if (take) begin
      nxt_st.lockout = det_lock;
      nxt_st.back    = det_back;
      nxt_st.orient  = det_orient;
    end
    // first detection after leaving standby always reports a change
    nxt_st.first_pending = !st_ff.enable || (st_ff.first_pending && !take);
    nxt_st.chg_flag = (st_ff.chg_flag && !status_read) || changed;

    // sticky interrupt causes, a new event beats a same-cycle clear
    events    = {take && det_lock && !st_ff.lockout, changed};
    nxt_st.irq_status = st_ff.irq_status | events;

    // write channel: address and data taken in either order
    if (aw_hs) begin
      nxt_st.aw_got  = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (w_hs) begin
      nxt_st.w_got   = 1'b1;
      nxt_st.w_data  = s_axi_wdata[7:0];
      nxt_st.w_lane0 = s_axi_wstrb[0];
    end
    if (do_write) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = orient_pkg::RESP_OKAY;
      unique case (st_ff.aw_addr)
        orient_pkg::ADDR_CTRL: begin
          if (st_ff.w_lane0) nxt_st.enable = st_ff.w_data[0];
        end
        orient_pkg::ADDR_IRQ_EN: begin
          if (st_ff.w_lane0) nxt_st.irq_enable = st_ff.w_data[1:0];
        end
        orient_pkg::ADDR_IRQ_CLR: begin
          if (st_ff.w_lane0) nxt_st.irq_status = (st_ff.irq_status & ~st_ff.w_data[1:0]) | events;
        end
        orient_pkg::ADDR_BFZ: begin
          if (st_ff.w_lane0) nxt_st.bfz = st_ff.w_data & 8'hC7;
        end
        orient_pkg::ADDR_TRIP: begin
          if (st_ff.w_lane0) nxt_st.trip = st_ff.w_data;
        end
        orient_pkg::ADDR_STATUS, orient_pkg::ADDR_IRQ_STAT: begin
          nxt_st.bresp = orient_pkg::RESP_OKAY;
        end
        default: nxt_st.bresp = orient_pkg::RESP_SLVERR;
      endcase
    end else if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // read channel: one read outstanding, data registered
    if (ar_hs) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = orient_pkg::RESP_OKAY;
      nxt_st.rdata  = 32'h00000000;
      unique case (s_axi_araddr)
        orient_pkg::ADDR_CTRL:     nxt_st.rdata = {31'h00000000, st_ff.enable};
        orient_pkg::ADDR_STATUS:   nxt_st.rdata = {24'h000000, st_ff.chg_flag, st_ff.lockout,
                                                   3'h0, st_ff.orient, st_ff.back};
        orient_pkg::ADDR_IRQ_STAT: nxt_st.rdata = {30'h00000000, st_ff.irq_status};
        orient_pkg::ADDR_IRQ_EN:   nxt_st.rdata = {30'h00000000, st_ff.irq_enable};
        orient_pkg::ADDR_IRQ_CLR:  nxt_st.rdata = 32'h00000000;
        orient_pkg::ADDR_BFZ:      nxt_st.rdata = {24'h000000, st_ff.bfz};
        orient_pkg::ADDR_TRIP:     nxt_st.rdata = {24'h000000, st_ff.trip};
        default:                   nxt_st.rresp = orient_pkg::RESP_SLVERR;
      endcase
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // synchronous reset; orientation starts at upright, front, no lockout
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff        <= '0;
      st_ff.bfz    <= orient_pkg::RST_BFZ;
      st_ff.trip   <= orient_pkg::RST_TRIP;
      st_ff.first_pending <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready     = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready      = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_bvalid      = st_ff.bvalid;
  assign s_axi_bresp       = st_ff.bresp;
  assign s_axi_arready     = !st_ff.rvalid;
  assign s_axi_rvalid      = st_ff.rvalid;
  assign s_axi_rdata       = st_ff.rdata;
  assign s_axi_rresp       = st_ff.rresp;
  assign orient_code       = st_ff.orient;
  assign back_facing       = st_ff.back;
  assign tilt_lockout_flag = st_ff.lockout;
  assign orient_change     = st_ff.chg_flag;
  assign irq               = |(st_ff.irq_status & st_ff.irq_enable);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_write_pair;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  sequence s_write_answer;
    ##[1:2] s_axi_bvalid;
  endsequence

  a_write_answer: assert property (s_write_pair |-> s_write_answer)
    else $error("write response missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped before bready");
  a_change_flag: assert property (changed |=> orient_change)
    else $error("change flag not raised");
  a_read_clears: assert property (status_read && !changed |=> !orient_change)
    else $error("status read did not clear change flag");
  a_lockout_freeze: assert property (take && tilt_over |=> $stable(orient_code))
    else $error("orientation moved under lockout");
  a_lockout_track: assert property (take |=> tilt_lockout_flag == $past(tilt_over))
    else $error("lockout flag does not follow tilt");
  a_idle_stable: assert property (!take |=> $stable({orient_code, back_facing}))
    else $error("orientation changed without sample");
  a_irq_sticky: assert property (changed |=> st_ff.irq_status[0])
    else $error("change event not latched for interrupt");
  a_reset_values: assert property (disable iff (1'b0)
      rst |=> st_ff.bfz == orient_pkg::RST_BFZ && st_ff.trip == orient_pkg::RST_TRIP)
    else $error("threshold registers wrong after reset");
  a_back_needs_neg: assert property (take && !back_facing && !accel_z[13] |=> !back_facing)
    else $error("went back with positive z");
endmodule

/* File: sim/accel_src.sv */
// sample source model standing in for the accelerometer front end
`timescale 1ns/1ns
module accel_src (
  input  wire logic               clk,
  output logic                    sample_valid,
  output logic signed [13:0]      accel_x,
  output logic signed [13:0]      accel_y,
  output logic signed [13:0]      accel_z
);
  initial begin
    sample_valid = 1'b0;
    accel_x      = 14'h0000;
    accel_y      = 14'h0000;
    accel_z      = 14'h0000;
  end

  // one-cycle strobe; axes scrambled afterwards so stale data cannot pass for valid
  task automatic send(input logic signed [13:0] x, input logic signed [13:0] y,
                      input logic signed [13:0] z);
    @(posedge clk);
    sample_valid <= 1'b1;
    accel_x      <= x;
    accel_y      <= y;
    accel_z      <= z;
    @(posedge clk);
    sample_valid <= 1'b0;
    accel_x      <= ~x;
    accel_y      <= ~y;
    accel_z      <= ~z;
  endtask
endmodule

/* File: sim/tb.sv */
// self-checking bench: axi4-lite register access and orientation scenarios
`timescale 1ns/1ns
module tb;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic               arvalid = 1'b0, rready = 1'b0;
  logic [7:0]         awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]        wdata = 32'h00000000;
  logic [3:0]         wstrb = 4'hF;
  logic               awready, wready, bvalid, arready, rvalid;
  logic [1:0]         bresp, rresp, orient_code;
  logic [31:0]        rdata;
  logic               sample_valid, back_facing, tilt_lockout_flag, orient_change, irq;
  logic signed [13:0] accel_x, accel_y, accel_z;
  int                 mismatches = 0;
  int                 checks = 0;

  // 20 ns period
  always #10 clk = ~clk;

  orientation_threshold_config u_dut (
    .clk(clk), .rst(rst),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .sample_valid(sample_valid),
    .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
    .orient_code(orient_code), .back_facing(back_facing),
    .tilt_lockout_flag(tilt_lockout_flag), .orient_change(orient_change), .irq(irq)
  );

  accel_src u_src (
    .clk(clk), .sample_valid(sample_valid),
    .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z)
  );

  ////////////////////////////////////////////////////////////////////////////
  // compare and verdict
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    // look mid-cycle, away from the edge that launches the output
    @(negedge clk);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // bus tasks; readies come from registers, so the negedge view equals the edge view
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw, got_b;
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= a;
    wdata   <= d;
    bready  <= 1'b1;
    got_b = 1'b0;
    // each valid drops only after the edge that took it; bready waits for the answer
    while (!got_b) begin
      @(negedge clk);
      ta    = awvalid && awready;
      tw    = wvalid && wready;
      got_b = bvalid;
      if (got_b) chk_word({30'h0, bresp}, {30'h0, r});
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic got_a, got_r;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    got_a = 1'b0;
    while (!got_a) begin
      @(negedge clk);
      got_a = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    rready  <= 1'b1;
    got_r = 1'b0;
    while (!got_r) begin
      @(negedge clk);
      got_r = rvalid;
      if (got_r) begin
        chk_word(rdata, d);
        chk_word({30'h0, rresp}, {30'h0, r});
      end
      @(posedge clk);
    end
    rready <= 1'b0;
  endtask

  // one sample, then the status word; reading also clears the change bit
  task automatic smp(input logic signed [13:0] x, input logic signed [13:0] y,
                     input logic signed [13:0] z, input logic [31:0] st);
    u_src.send(x, y, z);
    @(negedge clk);
    chk_word({24'h000000, orient_change, tilt_lockout_flag, 3'h0, orient_code, back_facing},
             st);
    rd(orient_pkg::ADDR_STATUS, st, orient_pkg::RESP_OKAY);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict();
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(orient_pkg::ADDR_BFZ, 32'h00000084, 2'h0);
    rd(orient_pkg::ADDR_TRIP, 32'h00000044, 2'h0);
    rd(8'h20, 32'h00000000, orient_pkg::RESP_SLVERR);
    wr(8'h20, 32'h00000001, orient_pkg::RESP_SLVERR);
    wr(orient_pkg::ADDR_CTRL, 32'h00000001, 2'h0);
    wr(orient_pkg::ADDR_IRQ_EN, 32'h00000001, 2'h0);
    smp(14'sd0, -14'sd4096, 14'sd0, 32'h00000080);
    chk_bit(irq, 1'b1);
    wr(orient_pkg::ADDR_IRQ_CLR, 32'h00000003, 2'h0);
    chk_bit(irq, 1'b0);
    wr(orient_pkg::ADDR_IRQ_EN, 32'h00000000, 2'h0);
    smp(14'sd0, 14'sd4096, 14'sd0, 32'h00000082);
    chk_bit(irq, 1'b0);
    smp(14'sd4096, 14'sd0, 14'sd0, 32'h00000084);
    smp(-14'sd4096, 14'sd0, 14'sd0, 32'h00000086);
    smp(-14'sd4096, 14'sd0, 14'sd0, 32'h00000006);
    smp(14'sd6000, 14'sd0, 14'sd0, 32'h00000006);
    // 60 degrees off the x axis: held by wide hysteresis, trips at 45
    wr(orient_pkg::ADDR_TRIP, 32'h00000087, 2'h0);
    smp(-14'sd2048, 14'sd3547, 14'sd0, 32'h00000006);
    wr(orient_pkg::ADDR_TRIP, 32'h00000080, 2'h0);
    smp(-14'sd2048, 14'sd3547, 14'sd0, 32'h00000082);
    // 26 degree tilt: free at the widest lockout code, locked at the narrowest
    wr(orient_pkg::ADDR_BFZ, 32'h00000007, 2'h0);
    smp(14'sd0, 14'sd4096, 14'sd2000, 32'h00000002);
    wr(orient_pkg::ADDR_BFZ, 32'h00000000, 2'h0);
    smp(14'sd0, 14'sd4096, 14'sd2000, 32'h000000C2);
    chk_bit(tilt_lockout_flag, 1'b1);
    // shallow face-down tilt: back only with the narrowest margin code
    wr(orient_pkg::ADDR_BFZ, 32'h000000C0, 2'h0);
    smp(14'sd0, -14'sd4096, -14'sd900, 32'h00000080);
    wr(orient_pkg::ADDR_BFZ, 32'h00000000, 2'h0);
    smp(14'sd0, -14'sd4096, -14'sd900, 32'h00000081);
    chk_bit(back_facing, 1'b1);
    smp(14'sd0, -14'sd4096, 14'sd900, 32'h00000080);
    wr(orient_pkg::ADDR_BFZ, 32'h000000FF, 2'h0);
    rd(orient_pkg::ADDR_BFZ, 32'h000000C7, 2'h0);
    // lane 0 off: the write is answered but leaves the register alone
    wstrb <= 4'h0;
    wr(orient_pkg::ADDR_TRIP, 32'h000000FF, 2'h0);
    wstrb <= 4'hF;
    rd(orient_pkg::ADDR_TRIP, 32'h00000080, 2'h0);
    rd(orient_pkg::ADDR_IRQ_CLR, 32'h00000000, 2'h0);
    rd(orient_pkg::ADDR_IRQ_STAT, 32'h00000003, 2'h0);
    // detector stopped: samples leave the state alone
    wr(orient_pkg::ADDR_CTRL, 32'h00000000, 2'h0);
    smp(14'sd4096, 14'sd0, 14'sd0, 32'h00000000);
    print_verdict();
  end
endmodule
